// File: logic/sys_reset_clock_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
`include "rst_seq_map.svh"

module sys_reset_clock_sequencer
  import rst_seq_pkg::*;
(
  // Clock, reset and enable
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Register port
  input  wire reg_req_type reg_req,
  output logic       [7:0] reg_rdata_q,
  // Clock sources
  input  wire logic        osc_reference_clock,
  input  wire logic        external_osc_clock,
  input  wire logic        internal_gen_clock,
  // Reset and mode sources
  input  wire logic        power_up_pulse,
  input  wire logic        undervoltage_detect,
  input  wire logic        watchdog_overflow,
  input  wire logic        illegal_opcode_detect,
  input  wire logic        opcode_fetch,
  input  wire logic        unmapped_access,
  input  wire logic        stop_exec,
  input  wire logic        wait_exec,
  input  wire logic        wake_event,
  input  wire logic        monitor_mode,
  // Reset pin, open drain
  input  wire logic        reset_pin_in,
  output logic             reset_pin_out,
  output logic             reset_pin_oe,
  // Reset and clock outputs
  output logic             internal_reset_signal,
  output logic      [15:0] reset_vector_q,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             cpu_bus_clock_q,
  output logic             periph_bus_clock_q,
  output logic             clock_gen_enable,
  output logic             watchdog_clock
);

  seq_state_type state_q;
  seq_state_type state_d;
  cfg_type       cfg_q;
  cfg_type       cfg_d;
  logic    [7:0] cause_q;
  logic    [7:0] cause_d;
  logic    [7:0] rdata_d;
  logic    [6:0] ext_cnt_q;
  logic    [6:0] ext_cnt_d;
  logic    [1:0] div_q;
  logic    [1:0] div_d;
  logic   [11:0] count;
  logic          ref_q;
  logic          src_q;
  logic          src;
  logic          tick;
  logic          wrap;
  logic          hit32;
  logic          hit64;
  logic          rec_done;
  logic          pin_low;
  logic          uv_req;
  logic          wd_req;
  logic          illegal_opcode_flag_req;
  logic          illegal_address_flag_req;
  logic          int_req;
  logic          accept_int;
  logic          go_power;
  logic          enter_int;
  logic          enter_stop;
  logic          stop_wake;
  logic          go_ext;
  logic          ext_hit;
  logic          cnt_clr;
  logic          cpu_run;
  logic          periph_run;
  logic          st_power;
  logic          st_drive;
  logic          st_hold;
  logic          st_ext;
  logic          st_run;
  logic          st_wait;
  logic          st_stop;
  logic          st_recover;

  // Flat view of the state register, shared by the decoders below
  assign st_power   = (state_q == S_POWER);
  assign st_drive   = (state_q == S_DRIVE);
  assign st_hold    = (state_q == S_HOLD);
  assign st_ext     = (state_q == S_EXT);
  assign st_run     = (state_q == S_RUN);
  assign st_wait    = (state_q == S_WAIT);
  assign st_stop    = (state_q == S_STOP);
  assign st_recover = (state_q == S_RECOVER);

  // Span end: a reference fall while the counter shows the span's last value
  function automatic logic span_end(input logic t, input logic [11:0] c, input logic [11:0] last);
    span_end = t && (c == last);
  endfunction

  // Reference falling edge; inputs are already synchronous
  assign tick = ref_q && !osc_reference_clock;

  // Shared 12-bit stabilisation counter
  stab_counter u_stab (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .tick    (tick),
    .clr     (cnt_clr),
    .count_q (count),
    .wrap    (wrap)
  );

  // Counter overflow doubles as watchdog clock
  assign watchdog_clock = wrap;

  // Span ends measured on the shared counter
  assign hit32    = span_end(tick, count, `CNT_32_LAST);
  assign hit64    = span_end(tick, count, `CNT_64_LAST);
  assign rec_done = cfg_q.short_rec ? hit32 : wrap;

  // Request decoding
  assign uv_req   = undervoltage_detect && !cfg_q.uv_pwr_down && !cfg_q.uv_rst_dis;
  assign wd_req   = watchdog_overflow && !cfg_q.wd_dis;
  assign illegal_opcode_flag_req = illegal_opcode_detect || (stop_exec && !cfg_q.stop_en);
  assign illegal_address_flag_req = opcode_fetch && unmapped_access;
  assign int_req  = wd_req || illegal_opcode_flag_req || illegal_address_flag_req;

  // Watchdog taken in wait too, not tied to the bus clock phase
  assign accept_int = st_run || st_wait;
  assign go_power   = power_up_pulse || uv_req;
  assign enter_int  = accept_int && int_req && !go_power;

  // Our own drive reads back low; only a foreign low counts
  assign pin_low    = !reset_pin_in && !reset_pin_oe;
  assign go_ext     = pin_low && !go_power && !enter_int
                      && (st_run || st_wait || st_recover);
  assign enter_stop = st_run && stop_exec && cfg_q.stop_en && !enter_int && !go_ext && !go_power;
  assign stop_wake  = wake_event || pin_low;

  // Clear on internal resets, stop entry and while stopped; pin reset leaves it
  assign cnt_clr = go_power || enter_int || enter_stop || st_stop;

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_POWER: begin
        if (wrap) begin
          state_d = S_DRIVE;
        end
      end
      S_DRIVE: begin
        if (hit32) begin
          state_d = S_HOLD;
        end
      end
      S_HOLD: begin
        if (hit64) begin
          state_d = S_RUN;
        end
      end
      S_EXT: begin
        if (reset_pin_in) begin
          state_d = S_RUN;
        end
      end
      S_RUN: begin
        if (wait_exec) begin
          state_d = S_WAIT;
        end else if (enter_stop) begin
          state_d = S_STOP;
        end
      end
      S_WAIT: begin
        if (wake_event) begin
          state_d = S_RUN;
        end
      end
      S_STOP: begin
        if (stop_wake) begin
          state_d = S_RECOVER;
        end
      end
      S_RECOVER: begin
        if (rec_done) begin
          state_d = S_RUN;
        end
      end
    endcase
    // Reset sources override the sequence
    if (go_power) begin
      state_d = S_POWER;
    end else if (enter_int) begin
      state_d = S_DRIVE;
    end else if (go_ext) begin
      state_d = S_EXT;
    end
  end

  // Internal reset and pin drive
  assign internal_reset_signal = st_power || st_drive
                                 || st_hold || st_ext;
  assign reset_pin_oe  = st_power || st_drive;
  assign reset_pin_out = 1'b0;

  // Clock gating; wait leaves peripheral gating to each module
  assign cpu_run          = st_run;
  assign periph_run       = st_run || st_wait;
  assign cpu_clk_en       = cpu_run;
  assign periph_clk_en    = periph_run;
  assign clock_gen_enable = !st_stop;

  // Divide the chosen source by four
  assign src   = cfg_q.clk_sel ? internal_gen_clock : external_osc_clock;
  assign div_d = (src && !src_q) ? div_q + `DIV_ONE : div_q;

  // Pin low time, saturating at the minimum
  assign ext_cnt_d = !st_ext ? `EXT_ZERO
                     : ((tick && ext_cnt_q != `EXT_MIN) ? ext_cnt_q + `EXT_ONE : ext_cnt_q);
  assign ext_hit   = st_ext && tick && (ext_cnt_d == `EXT_MIN) && (ext_cnt_q != `EXT_MIN);

  // Cause flags: latest source only, power-up wins
  always_comb begin
    cause_d = cause_q;
    if (power_up_pulse) begin
      cause_d = `CAUSE_POR;
    end else if (uv_req && !st_power) begin
      cause_d = `CAUSE_UV;
    end else if (enter_int && wd_req) begin
      cause_d = `CAUSE_WD;
    end else if (enter_int && illegal_opcode_flag_req) begin
      cause_d = `CAUSE_ILLEGAL_OPCODE_FLAG;
    end else if (enter_int) begin
      cause_d = `CAUSE_ILLEGAL_ADDRESS_FLAG;
    end else if (ext_hit) begin
      cause_d = `CAUSE_PIN;
    end
  end

  // Config write; held at defaults under internal reset
  assign cfg_d = internal_reset_signal ? cfg_type'(`CFG_RESET)
                 : ((reg_req.wr && reg_req.addr == `ADDR_CFG) ? cfg_type'(reg_req.wdata[5:0]) : cfg_q);

  // Read decode; cause register ignores writes
  assign rdata_d = !reg_req.rd ? `RDATA_IDLE
                   : (reg_req.addr == `ADDR_CAUSE) ? cause_q
                   : (reg_req.addr == `ADDR_CFG) ? {2'b00, cfg_q}
                   : `RDATA_IDLE;

  // Sequencer and flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= S_POWER;
      cause_q   <= `CAUSE_POR;
      ext_cnt_q <= `EXT_ZERO;
    end else if (ce) begin
      state_q   <= state_d;
      cause_q   <= cause_d;
      ext_cnt_q <= ext_cnt_d;
    end
  end

  // Configuration and read data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q       <= cfg_type'(`CFG_RESET);
      reg_rdata_q <= `RDATA_IDLE;
    end else if (ce) begin
      cfg_q       <= cfg_d;
      reg_rdata_q <= rdata_d;
    end
  end

  // Edge samples, divider and gated bus clocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_q              <= 1'b0;
      src_q              <= 1'b0;
      div_q              <= 2'h0;
      cpu_bus_clock_q    <= 1'b0;
      periph_bus_clock_q <= 1'b0;
    end else if (ce) begin
      ref_q              <= osc_reference_clock;
      src_q              <= src;
      div_q              <= div_d;
      cpu_bus_clock_q    <= div_d[1] && cpu_run;
      periph_bus_clock_q <= div_d[1] && periph_run;
    end
  end

  // Vector chosen while the reset is held
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_vector_q <= `VEC_NORMAL;
    end else if (ce && internal_reset_signal) begin
      reset_vector_q <= monitor_mode ? `VEC_MONITOR : `VEC_NORMAL;
    end
  end

endmodule
`default_nettype wire

// File: logic/rst_seq_map.svh
`ifndef RST_SEQ_MAP_SVH
`define RST_SEQ_MAP_SVH

// Register offsets
`define ADDR_CAUSE   8'h01
`define ADDR_CFG     8'h02

// Reset values
`define CFG_RESET    6'h00
`define CAUSE_POR    8'h80
`define CAUSE_PIN    8'h40
`define CAUSE_WD     8'h20
`define CAUSE_ILLEGAL_OPCODE_FLAG   8'h10
`define CAUSE_ILLEGAL_ADDRESS_FLAG   8'h08
`define CAUSE_UV     8'h02
`define RDATA_IDLE   8'h00

// Reset vectors
`define VEC_NORMAL   16'hFFFE
`define VEC_MONITOR  16'hFEFE

// Reference cycle counts, last count value of each span
`define CNT_ZERO     12'h000
`define CNT_ONE      12'h001
`define CNT_MAX      12'hFFF
`define CNT_32_LAST  12'h01F
`define CNT_64_LAST  12'h03F
`define EXT_ZERO     7'h00
`define EXT_ONE      7'h01
`define EXT_MIN      7'h43
`define DIV_ONE      2'h1

`endif

// File: logic/rst_seq_pkg.sv
package rst_seq_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    S_POWER,
    S_DRIVE,
    S_HOLD,
    S_EXT,
    S_RUN,
    S_WAIT,
    S_STOP,
    S_RECOVER
  } seq_state_type;

  // Configuration register layout, bit 0 first from the right
  typedef struct packed {
    logic clk_sel;
    logic uv_rst_dis;
    logic uv_pwr_down;
    logic stop_en;
    logic wd_dis;
    logic short_rec;
  } cfg_type;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_type;

endpackage

// File: logic/stab_counter.sv
`timescale 1ns/100ps
`default_nettype none
`include "rst_seq_map.svh"

module stab_counter (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Control
  input  wire logic        tick,
  input  wire logic        clr,
  // State
  output logic      [11:0] count_q,
  output logic             wrap
);

  logic [11:0] count_d;

  // Clear wins over a tick in the same cycle
  assign count_d = clr ? `CNT_ZERO : (tick ? count_q + `CNT_ONE : count_q);
  assign wrap    = tick && !clr && (count_q == `CNT_MAX);

  // Free running once nobody clears it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= `CNT_ZERO;
    end else if (ce) begin
      count_q <= count_d;
    end
  end

endmodule
`default_nettype wire

// File: dv/rst_seq_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "rst_seq_map.svh"
module rst_seq_asserts
  import rst_seq_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Watched ports
  input wire reg_req_type reg_req,
  input wire logic [7:0]  reg_rdata_q,
  input wire logic        osc_reference_clock,
  input wire logic        monitor_mode,
  input wire logic        wait_exec,
  input wire logic        stop_exec,
  input wire logic        opcode_fetch,
  input wire logic        unmapped_access,
  input wire logic        reset_pin_oe,
  input wire logic        internal_reset_signal,
  input wire logic [15:0] reset_vector_q,
  input wire logic        cpu_clk_en,
  input wire logic        periph_clk_en
);
  logic        ref_q;
  logic        drove_q;
  logic [6:0]  hold_q;
  logic [12:0] drv_q;
  wire logic   tk = ref_q & ~osc_reference_clock;

  // Reference ticks per reset phase; counted, not assumed from clk
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_q   <= 1'b0;
      drove_q <= 1'b0;
      hold_q  <= 7'h00;
      drv_q   <= 13'h0000;
    end else begin
      ref_q   <= osc_reference_clock;
      drove_q <= internal_reset_signal & (drove_q | reset_pin_oe);
      hold_q  <= (internal_reset_signal & ~reset_pin_oe) ? hold_q + 7'(tk) : 7'h00;
      drv_q   <= reset_pin_oe ? drv_q + 13'(tk) : 13'h0000;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Reset sequencing
  property p_oe_rst; reset_pin_oe |-> internal_reset_signal; endproperty
  a_oe_rst: assert property (p_oe_rst) else $error("pin driven outside reset");
  property p_drv; $fell(reset_pin_oe) |-> drv_q >= 13'h001F; endproperty
  a_drv: assert property (p_drv) else $error("pin drive too short");
  property p_hold; $fell(internal_reset_signal) && drove_q |-> hold_q inside {[7'h1F:7'h21]}; endproperty
  a_hold: assert property (p_hold) else $error("reset hold not 32 ticks");
  property p_vec;
    internal_reset_signal ##1 internal_reset_signal |->
      reset_vector_q == ($past(monitor_mode) ? `VEC_MONITOR : `VEC_NORMAL);
  endproperty
  a_vec: assert property (p_vec) else $error("wrong reset vector");
  property p_rdata; !$past(reg_req.rd) |-> reg_rdata_q == `RDATA_IDLE; endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside slot");
  // Mode entry and illegal fetch
  property p_wait; wait_exec && cpu_clk_en |=> !cpu_clk_en && periph_clk_en; endproperty
  a_wait: assert property (p_wait) else $error("wait clocks wrong");
  property p_stop; stop_exec && cpu_clk_en |=> !cpu_clk_en; endproperty
  a_stop: assert property (p_stop) else $error("cpu clock runs after stop");
  property p_illegal_address_flag; opcode_fetch && unmapped_access && cpu_clk_en |=> internal_reset_signal && reset_pin_oe;
  endproperty
  a_illegal_address_flag: assert property (p_illegal_address_flag) else $error("illegal fetch not reset");
  c_wait: cover property (wait_exec && cpu_clk_en);
  c_stop: cover property (stop_exec && cpu_clk_en);
  c_hold: cover property ($fell(internal_reset_signal) && drove_q);
endmodule
`default_nettype wire

// File: dv/rst_far_side.sv
`timescale 1ns/100ps
`default_nettype none
module rst_far_side (
  // Bus clock
  input  wire logic clk,
  // Reset line parties
  input  wire logic reset_pin_oe,
  input  wire logic pin_low_drive,
  output logic      reset_pin_in,
  // Oscillators
  output logic      osc_reference_clock,
  output logic      external_osc_clock,
  output logic      internal_gen_clock
);
  logic [1:0] div_q = 2'h0;

  // Pull-up line: low while either party pulls it
  assign reset_pin_in = ~(reset_pin_oe | pin_low_drive);
  // Slow reference so every fall is seen at clk
  always_ff @(posedge clk) begin
    div_q <= div_q + 2'h1;
  end
  assign osc_reference_clock = div_q[1];
  assign external_osc_clock  = div_q[0];
  assign internal_gen_clock  = div_q[1];
endmodule
`default_nettype wire

// File: dv/test_sys_reset_clock_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
`include "rst_seq_map.svh"
module test_sys_reset_clock_sequencer;
  import rst_seq_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, monitor_mode = 1'b0, pin_low_drive = 1'b0, rd_q = 1'b0;
  logic [8:0]  ev = 9'h000;
  reg_req_type reg_req = '0;
  wire logic   power_up_pulse, undervoltage_detect, watchdog_overflow, illegal_opcode_detect, opcode_fetch;
  wire logic   unmapped_access, stop_exec, wait_exec, wake_event, reset_pin_in, osc_reference_clock;
  wire logic   external_osc_clock, internal_gen_clock;
  logic [7:0]  reg_rdata_q;
  logic [15:0] reset_vector_q;
  logic        reset_pin_out, reset_pin_oe, internal_reset_signal, cpu_clk_en, periph_clk_en;
  logic        cpu_bus_clock_q, periph_bus_clock_q, clock_gen_enable, watchdog_clock;
  int          miscompares = 0, num_checks = 0, cyc = 0, n;
  logic [7:0]  exp_q[$];
  logic [8:0]  src_t[4] = '{9'h001, 9'h002, 9'h00C, 9'h080};
  logic [7:0]  cse_t[4] = '{`CAUSE_WD, `CAUSE_ILLEGAL_OPCODE_FLAG, `CAUSE_ILLEGAL_ADDRESS_FLAG, `CAUSE_UV};

  // Event pulses, one bit per source
  assign {power_up_pulse, undervoltage_detect, wake_event, wait_exec, stop_exec, unmapped_access,
          opcode_fetch, illegal_opcode_detect, watchdog_overflow} = ev;
  sys_reset_clock_sequencer dut_u (.*);
  rst_far_side far_u (.*);

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard; three 4096-tick sequences dominate the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [15:0] e, g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", what, e, g);
    end
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_q) chk("rdata", {8'h00, exp_q.pop_front()}, {8'h00, reg_rdata_q});
    rd_q <= reg_req.rd;
  end

  task automatic wr(input logic [7:0] a, d);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    reg_req <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, e);
    exp_q.push_back(e);
    reg_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    reg_req <= '0;
    @(posedge clk);
  endtask
  task automatic pulse(input logic [8:0] m);
    ev <= m;
    @(posedge clk);
    ev <= 9'h000;
    @(posedge clk);
  endtask
  task automatic to_run();
    while (internal_reset_signal !== 1'b0 || cpu_clk_en !== 1'b1) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
  // Rising edges of the gated bus clock over 128 cycles
  task automatic bus_rate(input int e);
    logic p;
    n = 0;
    repeat (128) begin
      p = cpu_bus_clock_q;
      @(posedge clk);
      n += int'(!p && cpu_bus_clock_q);
    end
    chk("bus rate", 1'b1, n >= e - 1 && n <= e + 1);
  endtask

  initial begin
    void'($urandom(32'h4F119D9B));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    to_run();
    chk("vector", `VEC_NORMAL, reset_vector_q);
    rd(`ADDR_CAUSE, `CAUSE_POR);
    wr(`ADDR_CAUSE, 8'($urandom));
    rd(`ADDR_CAUSE, `CAUSE_POR);
    rd(8'h03 + 8'($urandom % 250), `RDATA_IDLE);
    pulse(9'h008);
    chk("data fetch", 1'b0, internal_reset_signal);
    // Enable low freezes the sequencer, so a watchdog pulse is lost
    ce <= 1'b0;
    pulse(9'h001);
    chk("ce freeze", 1'b0, internal_reset_signal);
    ce <= 1'b1;
    @(posedge clk);
    foreach (src_t[i]) begin
      monitor_mode <= 1'($urandom);
      pulse(src_t[i]);
      to_run();
      chk("vector", monitor_mode ? `VEC_MONITOR : `VEC_NORMAL, reset_vector_q);
      rd(`ADDR_CAUSE, cse_t[i]);
    end
    // Disabled watchdog and undervoltage requests are ignored
    wr(`ADDR_CFG, 8'h12);
    pulse(9'h081);
    chk("disabled", 1'b0, internal_reset_signal);
    wr(`ADDR_CFG, 8'h05);
    bus_rate(16);
    pulse(9'h010);
    chk("gen enable", 1'b0, clock_gen_enable);
    chk("periph stop", 1'b0, periph_clk_en);
    pulse(9'h040);
    n = 0;
    while (cpu_clk_en !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    chk("recovery", 1'b1, n >= 124 && n <= 136);
    pulse(9'h020);
    chk("wait cpu", 1'b0, cpu_clk_en);
    chk("wait periph", 1'b1, periph_clk_en);
    pulse(9'h040);
    to_run();
    wr(`ADDR_CFG, 8'h25);
    bus_rate(8);
    wr(`ADDR_CFG, 8'h00);
    pulse(9'h010);
    to_run();
    rd(`ADDR_CAUSE, `CAUSE_ILLEGAL_OPCODE_FLAG);
    // Pin held past the minimum width
    pin_low_drive <= 1'b1;
    repeat (320) @(posedge clk);
    pin_low_drive <= 1'b0;
    to_run();
    rd(`ADDR_CAUSE, `CAUSE_PIN);
    pulse(9'h100);
    to_run();
    rd(`ADDR_CAUSE, `CAUSE_POR);
    repeat (2) @(posedge clk);
    end_of_test();
  end
endmodule
bind sys_reset_clock_sequencer rst_seq_asserts chk_u (.*);
`default_nettype wire
